// file: core/ssrx_pkg.sv
// Shared constants and types for the synchronous serial receive/slave port.
// Assumes an APB slave on a 20 MHz system clock; the offsets are byte addresses.
//
// Contract
// - Master receive turns off the data pin driver; the pin is only an input.
// - Receiving starts when the single-shot or continuous enable is set.
// - Single-shot alone makes one character of clocks, then clears itself.
// - Continuous makes clocks until cleared; clearing it aborts the character.
// - With both set, single-shot clears after one character; continuous goes on.
// - Data is sampled on each trailing shift clock edge into the shifter.
// - A full character goes into the two-entry FIFO and sets the pending flag.
// - The data register shows the oldest entry; pending stays set while unread.
// - Slave mode takes the clock from the pin and never drives that pin.
// - Data changes on the leading edge, is valid at trailing; one bit per clock.
// - A third character into a full FIFO sets overrun, keeps data, stops reception.
// - Overrun clears on data read in single-shot, or on clearing continuous.
// - Clearing the port enable resets the serial unit and the overrun.
// - Nine-bit mode shifts nine bits; the ninth of the oldest entry is in status.
// - Slave: clocked mode, external clock, enabled; no receive enable means send; the code also needs the transmit enable set.
// - Slave send: second word waits until the first is out, then empty flag sets.
// - Empty flag in sleep with enables set wakes; global enable asks service.
// - Master mode drives the shift clock on the clock pin, one per bit.
// - No start or stop bits; characters are data bits only.

package ssrx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RX_CTRL = 8'h00;
  localparam logic [7:0] OFF_TX_CTRL = 8'h04;
  localparam logic [7:0] OFF_RX_DATA = 8'h08;
  localparam logic [7:0] OFF_TX_DATA = 8'h0C;
  localparam logic [7:0] OFF_RATE    = 8'h10;
  localparam logic [7:0] OFF_IRQ     = 8'h14;

  // Field positions of rx_status_control
  localparam int unsigned RX_SERIAL_PORT_ENABLE  = 7;
  localparam int unsigned RX_NINE  = 6;
  localparam int unsigned RX_SINGLE = 5;
  localparam int unsigned RX_CONT  = 4;
  localparam int unsigned RX_ADDR  = 3;

  // Field positions of tx_status_control
  localparam int unsigned TX_CLOCK_SOURCE_SELECT  = 7;
  localparam int unsigned TX_NINE  = 6;
  localparam int unsigned TX_EN    = 5;
  localparam int unsigned TX_SYNC  = 4;
  localparam int unsigned TX_HIGH  = 2;
  localparam int unsigned TX_NINTH = 0;

  // Field positions of the interrupt control register
  localparam int unsigned IRQ_GLOBAL = 0;
  localparam int unsigned IRQ_PERIPH = 1;
  localparam int unsigned IRQ_RX     = 2;
  localparam int unsigned IRQ_TX     = 3;
  localparam int unsigned IRQ_SLEEP  = 4;

  // Reset values
  localparam logic [7:0] RST_RX_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_CTRL = 8'h02;
  localparam logic [7:0] RST_DATA    = 8'h00;

  // Character lengths
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG  = 4'h9;

  // Pin drive bundle: value and enable of both two-way pins
  typedef struct packed {
    logic clock_out;
    logic clock_oe;
    logic data_out;
    logic data_oe;
  } ssrx_pins_type;

endpackage : ssrx_pkg

// file: core/ssrx_top.sv
// Synchronous serial port: master reception, slave transmit and reception.
// Assumes an APB master on clock, pins resolved outside from the enables.
`timescale 1ns/1ps
`default_nettype none

module ssrx_top
#(
  parameter int ADDR_W     = 8,
  parameter int FIFO_DEPTH = 2
)
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  clock_pin_in,
  input  wire logic                  data_pin_in,
  output ssrx_pkg::ssrx_pins_type    pins,
  output logic                       wake_request,
  output logic                       service_request
);
  import ssrx_pkg::*;

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [PTR_W:0] FULL_COUNT = FIFO_DEPTH[PTR_W:0];

  // Control and status bits
  logic       serial_port_enable;
  logic       nine_bit_receive_select;
  logic       single_shot_receive_enable;
  logic       continuous_receive_enable;
  logic       address_match_enable;
  logic       overrun_flag;
  logic       clock_source_select;
  logic       nine_bit_transmit_select;
  logic       transmit_enable_bit;
  logic       sync_mode;
  logic       high_rate_select;
  logic       transmit_ninth_bit;
  logic [7:0] rate_divisor;
  logic       global_irq_enable;
  logic       peripheral_irq_enable;
  logic       receive_irq_enable;
  logic       transmit_irq_enable;
  logic       core_sleeping;

  // Receive path state
  logic [8:0]       receive_shifter;
  logic [3:0]       rx_bit_count;
  logic [8:0]       fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W:0]   fifo_count;

  // Transmit path state
  logic [7:0] transmit_data_holding;
  logic       tx_hold_ninth;
  logic       tx_hold_full;
  logic [8:0] transmit_shifter;
  logic       tx_busy;
  logic [3:0] tx_bit_count;
  logic       data_drive;

  // Master clock generator
  logic [7:0] div_count;
  logic       shift_clock;

  // Pin synchronisers and edge memory
  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic dat_meta;
  logic dat_sync;

  // Pointer step with wrap, shared by both FIFO pointers
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(FIFO_DEPTH - 1))
      ptr_step = '0;
    else
      ptr_step = p + PTR_W'(1);
  endfunction : ptr_step

  // APB decode; every access completes without wait states
  wire apb_access = psel & penable;
  wire apb_wr     = apb_access & pwrite;
  wire apb_rd     = apb_access & ~pwrite;
  wire hit_rx_ctrl = paddr[7:0] == OFF_RX_CTRL;
  wire hit_tx_ctrl = paddr[7:0] == OFF_TX_CTRL;
  wire hit_rx_data = paddr[7:0] == OFF_RX_DATA;
  wire hit_tx_data = paddr[7:0] == OFF_TX_DATA;
  wire hit_rate    = paddr[7:0] == OFF_RATE;
  wire hit_irq     = paddr[7:0] == OFF_IRQ;
  wire upper_zero  = (ADDR_W <= 8) ? 1'b1 : ~|(paddr >> 8);
  wire mapped      = upper_zero & (hit_rx_ctrl | hit_tx_ctrl | hit_rx_data
                     | hit_tx_data | hit_rate | hit_irq);
  wire wr_rx_ctrl  = apb_wr & upper_zero & hit_rx_ctrl;
  wire wr_tx_ctrl  = apb_wr & upper_zero & hit_tx_ctrl;
  wire wr_tx_data  = apb_wr & upper_zero & hit_tx_data;
  wire wr_rate     = apb_wr & upper_zero & hit_rate;
  wire wr_irq      = apb_wr & upper_zero & hit_irq;
  wire rd_rx_data  = apb_rd & upper_zero & hit_rx_data;

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~mapped;

  // Mode decode
  wire unit_clear = ~serial_port_enable;
  wire rx_mode    = single_shot_receive_enable
                    | continuous_receive_enable;
  wire master     = clock_source_select;
  wire sync_on    = serial_port_enable & sync_mode;
  wire rx_active  = sync_on & rx_mode & ~overrun_flag;
  wire tx_slave   = sync_on & ~master & transmit_enable_bit
                    & ~rx_mode;
  wire m_run      = rx_active & master;

  // Edges of the shift clock: ours in master mode, the pin's otherwise
  wire half_tick  = m_run & (div_count == rate_divisor);
  wire m_rise     = half_tick & ~shift_clock;
  wire m_fall     = half_tick & shift_clock;
  wire s_rise     = clk_sync & ~clk_prev;
  wire s_fall     = ~clk_sync & clk_prev;
  wire lead_edge  = master ? m_rise : s_rise;
  wire trail_edge = master ? m_fall : s_fall;

  // Receive decode
  wire [3:0] rx_bits   = nine_bit_receive_select ? BITS_LONG : BITS_SHORT;
  wire       rx_sample = rx_active & trail_edge;
  wire       rx_last   = rx_bit_count == (rx_bits - 4'h1);
  wire       char_done = rx_sample & rx_last;
  wire [8:0] next_shifter = {dat_sync, receive_shifter[8:1]};
  wire [8:0] next_char = nine_bit_receive_select ? next_shifter
                         : {1'b0, next_shifter[8:1]};
  wire       fifo_full  = fifo_count == FULL_COUNT;
  wire       fifo_empty = fifo_count == '0;
  wire       fifo_push  = char_done & ~fifo_full;
  wire       overrun_event = char_done & fifo_full;
  wire       fifo_pop   = rd_rx_data & ~fifo_empty;
  wire [8:0] fifo_head  = fifo_mem[rd_ptr];
  wire       head_ninth = ~fifo_empty & fifo_head[8]; // Reads 0 when empty; the memory has no reset
  wire       receive_pending_flag = ~fifo_empty;

  // Overrun removal: data read in single-shot, continuous cleared, port off
  wire cont_cleared = wr_rx_ctrl & ~pwdata[RX_CONT];
  wire overrun_clear = unit_clear | cont_cleared
                       | (rd_rx_data & ~continuous_receive_enable);

  // Transmit decode
  wire [3:0] tx_bits   = nine_bit_transmit_select ? BITS_LONG : BITS_SHORT;
  wire       tx_load   = tx_slave & ~tx_busy & tx_hold_full;
  wire       tx_done   = tx_busy & s_fall & (tx_bit_count == tx_bits);
  wire       transmit_empty_flag = ~tx_hold_full;
  wire       wake_cond = core_sleeping & peripheral_irq_enable
                         & ((transmit_irq_enable & transmit_empty_flag)
                         | (receive_irq_enable & receive_pending_flag));

  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      dat_meta <= 1'b0;
      dat_sync <= 1'b0;
    end
    else
    begin
      clk_meta <= clock_pin_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      dat_meta <= data_pin_in;
      dat_sync <= dat_meta;
    end
  end

  // Receive control register; a software write wins over the hardware clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      serial_port_enable         <= RST_RX_CTRL[RX_SERIAL_PORT_ENABLE];
      nine_bit_receive_select    <= RST_RX_CTRL[RX_NINE];
      single_shot_receive_enable <= RST_RX_CTRL[RX_SINGLE];
      continuous_receive_enable  <= RST_RX_CTRL[RX_CONT];
      address_match_enable       <= RST_RX_CTRL[RX_ADDR];
    end
    else if (wr_rx_ctrl)
    begin
      serial_port_enable         <= pwdata[RX_SERIAL_PORT_ENABLE];
      nine_bit_receive_select    <= pwdata[RX_NINE];
      single_shot_receive_enable <= pwdata[RX_SINGLE];
      continuous_receive_enable  <= pwdata[RX_CONT];
      address_match_enable       <= pwdata[RX_ADDR];
    end
    else if (char_done)
      single_shot_receive_enable <= 1'b0;
  end

  // Overrun flag: a new overrun beats a clear in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      overrun_flag <= 1'b0;
    else if (overrun_event)
      overrun_flag <= 1'b1;
    else if (overrun_clear)
      overrun_flag <= 1'b0;
  end

  // Transmit control and rate registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      clock_source_select      <= RST_TX_CTRL[TX_CLOCK_SOURCE_SELECT];
      nine_bit_transmit_select <= RST_TX_CTRL[TX_NINE];
      transmit_enable_bit      <= RST_TX_CTRL[TX_EN];
      sync_mode                <= RST_TX_CTRL[TX_SYNC];
      high_rate_select         <= RST_TX_CTRL[TX_HIGH];
      transmit_ninth_bit       <= RST_TX_CTRL[TX_NINTH];
      rate_divisor             <= RST_DATA;
    end
    else
    begin
      if (wr_tx_ctrl)
      begin
        clock_source_select      <= pwdata[TX_CLOCK_SOURCE_SELECT];
        nine_bit_transmit_select <= pwdata[TX_NINE];
        transmit_enable_bit      <= pwdata[TX_EN];
        sync_mode                <= pwdata[TX_SYNC];
        high_rate_select         <= pwdata[TX_HIGH];
        transmit_ninth_bit       <= pwdata[TX_NINTH];
      end
      if (wr_rate)
        rate_divisor <= pwdata[7:0];
    end
  end

  // Interrupt enables and sleep; a wake ends the sleep
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      global_irq_enable     <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      receive_irq_enable    <= 1'b0;
      transmit_irq_enable   <= 1'b0;
      core_sleeping         <= 1'b0;
      wake_request          <= 1'b0;
      service_request       <= 1'b0;
    end
    else
    begin
      wake_request    <= wake_cond;
      service_request <= wake_cond & global_irq_enable;
      if (wr_irq)
      begin
        global_irq_enable     <= pwdata[IRQ_GLOBAL];
        peripheral_irq_enable <= pwdata[IRQ_PERIPH];
        receive_irq_enable    <= pwdata[IRQ_RX];
        transmit_irq_enable   <= pwdata[IRQ_TX];
        core_sleeping         <= pwdata[IRQ_SLEEP];
      end
      else if (wake_cond)
        core_sleeping <= 1'b0;
    end
  end

  // Master shift clock: toggles every divisor+1 cycles, idles low
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_count   <= 8'h00;
      shift_clock <= 1'b0;
    end
    else if (!m_run)
    begin
      div_count   <= 8'h00;
      shift_clock <= 1'b0;
    end
    else if (half_tick)
    begin
      div_count   <= 8'h00;
      shift_clock <= ~shift_clock;
    end
    else
      div_count <= div_count + 8'h01;
  end

  // Receive shifter: data bits only, no framing bits
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      receive_shifter <= 9'h000;
      rx_bit_count    <= 4'h0;
    end
    else if (!rx_active)
      rx_bit_count <= 4'h0;
    else if (rx_sample)
    begin
      receive_shifter <= next_shifter;
      rx_bit_count    <= rx_last ? 4'h0 : rx_bit_count + 4'h1;
    end
  end

  // FIFO storage; stored entries are never overwritten
  always_ff @(posedge clock)
  begin
    if (fifo_push)
      fifo_mem[wr_ptr] <= next_char;
  end

  // FIFO pointers and fill level
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr     <= '0;
      wr_ptr     <= '0;
      fifo_count <= '0;
    end
    else if (unit_clear)
    begin
      rd_ptr     <= '0;
      wr_ptr     <= '0;
      fifo_count <= '0;
    end
    else
    begin
      if (fifo_push)
        wr_ptr <= ptr_step(wr_ptr);
      if (fifo_pop)
        rd_ptr <= ptr_step(rd_ptr);
      if (fifo_push && !fifo_pop)
        fifo_count <= fifo_count + (PTR_W+1)'(1);
      else if (fifo_pop && !fifo_push)
        fifo_count <= fifo_count - (PTR_W+1)'(1);
    end
  end

  // Transmit holding register; a write while it is full is dropped
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      transmit_data_holding <= RST_DATA;
      tx_hold_ninth         <= 1'b0;
      tx_hold_full          <= 1'b0;
    end
    else if (unit_clear)
      tx_hold_full <= 1'b0;
    else if (wr_tx_data && !tx_hold_full)
    begin
      transmit_data_holding <= pwdata[7:0];
      tx_hold_ninth         <= transmit_ninth_bit;
      tx_hold_full          <= 1'b1;
    end
    else if (tx_load)
      tx_hold_full <= 1'b0;
  end

  // Slave transmit shifter, clocked by edges of the pin clock
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      transmit_shifter <= 9'h000;
      tx_busy          <= 1'b0;
      tx_bit_count     <= 4'h0;
      data_drive       <= 1'b0;
    end
    else if (!tx_slave)
    begin
      tx_busy      <= 1'b0;
      tx_bit_count <= 4'h0;
    end
    else if (tx_load)
    begin
      transmit_shifter <= {tx_hold_ninth, transmit_data_holding};
      tx_busy          <= 1'b1;
      tx_bit_count     <= 4'h0;
    end
    else if (tx_done)
    begin
      tx_busy      <= 1'b0;
      tx_bit_count <= 4'h0;
    end
    else if (tx_busy && lead_edge && tx_bit_count != tx_bits)
    begin
      data_drive       <= transmit_shifter[0];
      transmit_shifter <= {1'b0, transmit_shifter[8:1]};
      tx_bit_count     <= tx_bit_count + 4'h1;
    end
  end

  // Pin drivers: clock only as master, data only in slave transmit
  assign pins = '{clock_out: shift_clock,
                  clock_oe:  sync_on & master,
                  data_out:  data_drive,
                  data_oe:   tx_slave};

  // Register read data; unused bits read as zero
  wire [7:0] rd_rx_ctrl = {serial_port_enable, nine_bit_receive_select,
                           single_shot_receive_enable,
                           continuous_receive_enable, address_match_enable,
                           1'b0, overrun_flag, head_ninth};
  wire [7:0] rd_tx_ctrl = {clock_source_select, nine_bit_transmit_select,
                           transmit_enable_bit, sync_mode, 1'b0,
                           high_rate_select, ~tx_busy, transmit_ninth_bit};
  wire [7:0] rd_irq     = {1'b0, transmit_empty_flag, receive_pending_flag,
                           core_sleeping, transmit_irq_enable,
                           receive_irq_enable, peripheral_irq_enable,
                           global_irq_enable};
  wire [7:0] rd_data    = fifo_empty ? RST_DATA : fifo_head[7:0];
  wire [7:0] rd_byte    = ~upper_zero ? 8'h00
                          : hit_rx_ctrl ? rd_rx_ctrl
                          : hit_tx_ctrl ? rd_tx_ctrl
                          : hit_rx_data ? rd_data
                          : hit_rate    ? rate_divisor
                          : hit_irq     ? rd_irq
                          : 8'h00;

  assign prdata = {24'h000000, rd_byte};

endmodule : ssrx_top

`default_nettype wire

// file: bench/ssrx_top_properties.sv
// Checker for the serial port: pin drivers, clock counts, bus answers.
// Assumes it is bound to ssrx_top and sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none

module ssrx_top_properties
  import ssrx_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [ADDR_W-1:0]       paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire ssrx_pkg::ssrx_pins_type pins,
  input wire logic                    wake_request,
  input wire logic                    service_request
);
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] irq_sh;
  logic [3:0] rises;
  logic       clk_q;
  wire logic  acc = psel && penable && pready;
  wire logic  wr_rx = acc && pwrite && paddr == ADDR_W'(OFF_RX_CTRL);
  wire logic  wr_tx = acc && pwrite && paddr == ADDR_W'(OFF_TX_CTRL);
  wire logic  wr_irq = acc && pwrite && paddr == ADDR_W'(OFF_IRQ);
  wire logic  master = rx_sh[RX_SERIAL_PORT_ENABLE] && tx_sh[TX_SYNC] && tx_sh[TX_CLOCK_SOURCE_SELECT];
  wire logic  bad = paddr > ADDR_W'(OFF_IRQ) || paddr[1:0] != 2'b00;
  wire logic [3:0] limit = rx_sh[RX_NINE] ? 4'h9 : 4'h8;

  // Software view of control bits; hardware-cleared bits are not tracked
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_sh <= 8'h00;
      tx_sh <= 8'h02;
      irq_sh <= 8'h00;
      rises <= 4'h0;
      clk_q <= 1'b0;
    end
    else
    begin
      clk_q <= pins.clock_out;
      if (wr_rx) rx_sh <= pwdata[7:0];
      if (wr_tx) tx_sh <= pwdata[7:0];
      if (wr_irq) irq_sh <= pwdata[7:0];
      if (wr_rx) rises <= 4'h0;
      else if (pins.clock_out && !clk_q && rises != 4'hF) rises <= rises + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_master_rx_input: assert property (master |-> !pins.data_oe)
    else $error("data pin driven in master receive");
  chk_master_clk_drive: assert property (master |-> pins.clock_oe)
    else $error("clock pin not driven in master mode");
  chk_slave_clk_in: assert property (!tx_sh[TX_CLOCK_SOURCE_SELECT] |-> !pins.clock_oe)
    else $error("clock pin driven in slave mode");
  chk_off_quiet: assert property (
    !rx_sh[RX_SERIAL_PORT_ENABLE] && !$past(rx_sh[RX_SERIAL_PORT_ENABLE]) |-> !pins.clock_oe && !pins.data_oe)
    else $error("pin driven with port disabled");
  chk_single_count: assert property (!rx_sh[RX_CONT] |-> rises <= limit)
    else $error("too many clocks in single-shot");
  chk_abort_stop: assert property (
    wr_rx && !pwdata[RX_CONT] && !pwdata[RX_SINGLE] |-> ##2 (!pins.clock_out) [*4])
    else $error("clock runs after receive cleared");
  chk_wake_service: assert property (
    service_request == (wake_request && $past(irq_sh[IRQ_GLOBAL])))
    else $error("service request disagrees with wake and global enable");
  chk_bus_ready: assert property (psel && penable |-> pready)
    else $error("access not answered");
  chk_unmapped_err: assert property (
    psel && penable && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");

  cover property (rises == 4'h8);
  cover property (pins.data_oe);
  cover property (service_request);

endmodule : ssrx_top_properties

bind ssrx_top ssrx_top_properties #(.ADDR_W(ADDR_W)) chk_i (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins),
  .wake_request(wake_request), .service_request(service_request)
);

`default_nettype wire

// file: bench/ssrx_peer.sv
// Far-side serial device: feeds the data pin under the port's clock and
// clocks slave frames itself. Assumes the bench resolves both pins.
`timescale 1ns/1ps
`default_nettype none

module ssrx_peer
(
  input  wire logic clk_pin,
  input  wire logic dat_pin,
  output logic      peer_clk,
  output logic      peer_data
);
  logic [8:0] word = 9'h000;
  logic [8:0] got = 9'h000;
  int         nbits = 8;
  int         idx = 0;

  initial peer_clk = 1'b0;
  initial peer_data = 1'b1;

  task automatic start(input logic [8:0] w, input int n);
    word = w;
    nbits = n;
    idx = 0;
  endtask : start

  // Next bit goes out on the leading edge, LSB first, no framing bits
  always @(posedge clk_pin)
  begin
    peer_data = word[idx];
    idx = (idx + 1 == nbits) ? 0 : idx + 1;
  end

  // Clock stands low outside frames; one cycle per bit, taken at trailing
  task automatic frame(input int n);
    got = 9'h000;
    #7;
    for (int i = 0; i < n; i++)
    begin
      #200 peer_clk = 1'b1;
      #200 peer_clk = 1'b0;
      got[i] = dat_pin;
    end
  endtask : frame

endmodule : ssrx_peer

`default_nettype wire

// file: bench/tb_sync_serial_rx_and_slave.sv
// Bench for the serial port: APB register traffic and a serial peer.
// Assumes ssrx_top, its checker bind and the peer model are compiled.
`timescale 1ns/1ps
`default_nettype none

module tb_sync_serial_rx_and_slave;
  import ssrx_pkg::*;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  ssrx_pins_type pins;
  logic          wake_request;
  logic          service_request;
  logic          peer_clk;
  logic          peer_data;
  logic          wake_seen = 1'b0;
  logic          svc_seen = 1'b0;
  logic [31:0]   rdata;
  logic          rerr;
  int            fails = 0;
  int            comparisons = 0;
  // Each pin carries whichever party has its driver on
  wire logic     clock_pin = pins.clock_oe ? pins.clock_out : peer_clk;
  wire logic     data_pin = pins.data_oe ? pins.data_out : peer_data;

  ssrx_top #(.ADDR_W(8), .FIFO_DEPTH(2)) uut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_pin_in(clock_pin),
    .data_pin_in(data_pin), .pins(pins), .wake_request(wake_request),
    .service_request(service_request));
  ssrx_peer peer (.clk_pin(clock_pin), .dat_pin(data_pin),
    .peer_clk(peer_clk), .peer_data(peer_data));

  initial forever #25 clock = ~clock;

  // Wake pulses are short, so latch them for later comparison
  always @(posedge clock)
  begin
    if (wake_request === 1'b1) wake_seen <= 1'b1;
    if (service_request === 1'b1) svc_seen <= 1'b1;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic hang();
    fails++;
    stop_test();
  endtask : hang

  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50) hang();
      @(posedge clock);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] mask,
                    input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    check(what, rdata & mask, exp);
  endtask : rd

  // Poll a status bit; a bound keeps a dead link from hanging the run
  task automatic wait_bit(input logic [7:0] a, input int b);
    int n;
    n = 0;
    xfer(1'b0, a, 32'h0);
    while (rdata[b] !== 1'b1)
    begin
      n++;
      if (n > 400) hang();
      xfer(1'b0, a, 32'h0);
    end
  endtask : wait_bit

  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFF_RX_CTRL, 32'hFFFFFFFF, 32'h00, "rx_ctrl reset");
    rd(OFF_TX_CTRL, 32'hFFFFFFFF, 32'h02, "tx_ctrl reset");
    rd(OFF_RX_DATA, 32'hFFFFFFFF, 32'h00, "rx_data reset");
    rd(8'h18, 32'hFFFFFFFF, 32'h00, "unmapped data");
    check("unmapped err", {31'h0, rerr}, 32'h1);
    // Master single-shot; divisor 3 keeps data clear of the sync delay
    xfer(1'b1, OFF_RATE, 32'h03);
    xfer(1'b1, OFF_TX_CTRL, 32'h90);
    xfer(1'b1, OFF_RX_CTRL, 32'h80);
    peer.start(9'h0A5, 8);
    xfer(1'b1, OFF_RX_CTRL, 32'hA0);
    wait_bit(OFF_IRQ, 5);
    rd(OFF_RX_CTRL, 32'hFF, 32'h80, "single clears");
    rd(OFF_RX_DATA, 32'hFF, 32'hA5, "single data");
    rd(OFF_IRQ, 32'h20, 32'h00, "pending drained");
    // Continuous until overrun, then clear it by clearing continuous and by port off
    peer.start(9'h03C, 8);
    xfer(1'b1, OFF_RX_CTRL, 32'h90);
    wait_bit(OFF_RX_CTRL, 1);
    rd(OFF_RX_CTRL, 32'hFF, 32'h92, "overrun set");
    rd(OFF_RX_DATA, 32'hFF, 32'h3C, "oldest kept");
    rd(OFF_IRQ, 32'h20, 32'h20, "pending stays");
    xfer(1'b1, OFF_RX_CTRL, 32'h80);
    rd(OFF_RX_CTRL, 32'hFF, 32'h80, "cont clears");
    xfer(1'b1, OFF_RX_CTRL, 32'h90);
    wait_bit(OFF_RX_CTRL, 1);
    xfer(1'b1, OFF_RX_CTRL, 32'h00);
    rd(OFF_RX_CTRL, 32'hFF, 32'h00, "unit reset");
    rd(OFF_IRQ, 32'h20, 32'h00, "fifo flushed");
    // Nine bits with both enables, then abort in mid character
    peer.start(9'h1C3, 9);
    xfer(1'b1, OFF_RX_CTRL, 32'hF0);
    wait_bit(OFF_IRQ, 5);
    rd(OFF_RX_CTRL, 32'hFF, 32'hD1, "ninth then cont");
    rd(OFF_RX_DATA, 32'hFF, 32'hC3, "nine low byte");
    xfer(1'b1, OFF_RX_CTRL, 32'h80);
    repeat (100) @(posedge clock);
    rd(OFF_IRQ, 32'h20, 32'h00, "partial dropped");
    // Slave transmit of two words across sleep
    xfer(1'b1, OFF_TX_CTRL, 32'h30);
    xfer(1'b1, OFF_IRQ, 32'h0B);
    xfer(1'b1, OFF_TX_DATA, 32'h5A);
    xfer(1'b1, OFF_TX_DATA, 32'h96);
    xfer(1'b1, OFF_IRQ, 32'h1B);
    rd(OFF_IRQ, 32'hFF, 32'h1B, "empty clear asleep");
    peer.frame(8);
    check("first word", {23'h0, peer.got}, 32'h5A);
    repeat (8) @(posedge clock);
    check("wake", {31'h0, wake_seen}, 32'h1);
    check("service", {31'h0, svc_seen}, 32'h1);
    rd(OFF_IRQ, 32'hFF, 32'h4B, "second moved");
    peer.frame(8);
    check("second word", {23'h0, peer.got}, 32'h96);
    stop_test();
  end

endmodule : tb_sync_serial_rx_and_slave

`default_nettype wire
